// >>> inc/pls_regs.svh
/*
  Constants of the parallel-load shift register: stage count, pin bundle
  width and the reset values of the stages and of the sampled pins.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH

// Number of stages in the shift chain
`define PLS_WIDTH 8
// Width of the sampled pin bundle: load, clock, inhibit, serial, parallel
`define PLS_PIN_W 12
// Stage contents after reset
`define PLS_STAGE_RESET 8'h00
// Sampled pins after reset: load high, clock and inhibit high, data low
`define PLS_PIN_RESET 12'hE00
// Synchroniser depth
`define PLS_SYNC_DEPTH 2

`endif

// >>> inc/pls_pkg.sv
/*
  Types of the parallel-load shift register: the pin bundle and the mode
  decoded from it.
  Assumes pls_regs.svh is on the include path.
*/
`default_nettype none
`include "pls_regs.svh"

package pls_pkg;

  // Pins from the host, kept together through the synchroniser
  typedef struct packed {
    logic shift_load_n;
    logic clock_in;
    logic clock_inhibit;
    logic serial_in;
    logic [`PLS_WIDTH-1:0] parallel_in;
  } pls_pins_t;

  // Mode of the chain as seen from the sampled pins
  typedef enum logic [1:0] {
    PLS_ST_LOAD  = 2'b00,
    PLS_ST_HELD  = 2'b01,
    PLS_ST_ARMED = 2'b10
  } pls_state_t;

endpackage

`default_nettype wire

// >>> src/pls_sync.sv
/*
  Two-stage synchroniser for the pin bundle of the shift register.
  Assumes all inputs are asynchronous to REF_CLK; the reset value is a
  constant so that no edge appears on the internal clock at release.
*/
`default_nettype none
`include "pls_regs.svh"

module pls_sync (
  input wire logic clk, // Reference clock
  input wire logic rst, // Asynchronous reset, active high
  input wire pls_pkg::pls_pins_t pins_async, // Raw pins
  output pls_pkg::pls_pins_t pins_sync // Pins after two flip-flops
);

  logic [`PLS_PIN_W-1:0] meta_reg;
  logic [`PLS_PIN_W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= `PLS_PIN_RESET;
    end else begin
      meta_reg <= pins_async;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= `PLS_PIN_RESET;
    end else begin
      sync_reg <= meta_reg;
    end
  end

  assign pins_sync = sync_reg;

endmodule

`default_nettype wire

// >>> src/pls_shift_register.sv
/*
  Eight-stage parallel-in, serial-out shift register with gated clock,
  continuous parallel load and complementary serial outputs.
  Assumes all pins arrive asynchronously to REF_CLK (10 MHz); the host's
  clock and inhibit must stay stable for at least three REF_CLK periods
  per level so that each internal clock edge is seen.
*/
`default_nettype none
`include "pls_regs.svh"

module pls_shift_register (
  input wire logic REF_CLK, // 10 MHz reference clock
  input wire logic RST, // Asynchronous reset, active high
  input wire logic SHIFT_LOAD_N, // Shift high, parallel load low
  input wire logic CLOCK_IN, // Gated clock input
  input wire logic CLOCK_INHIBIT, // Gated clock inhibit input
  input wire logic SERIAL_IN, // Serial data into first stage
  input wire logic [`PLS_WIDTH-1:0] PARALLEL_IN, // Direct stage data
  output logic FIRST_STAGE, // First stage content
  output logic LAST_STAGE_OUT, // Last stage, true
  output logic LAST_STAGE_OUT_N // Last stage, inverted
);

  pls_pkg::pls_pins_t pins_raw;
  pls_pkg::pls_pins_t pins;
  pls_pkg::pls_state_t state_reg;
  pls_pkg::pls_state_t state_next;
  logic [`PLS_WIDTH-1:0] stage_reg;
  logic [`PLS_WIDTH-1:0] stage_next;
  logic [`PLS_WIDTH-1:0] shifted;
  logic shift_pulse;

  // Mode from the sampled pins
  function automatic pls_pkg::pls_state_t decode_mode(
    input pls_pkg::pls_pins_t p
  );
    logic internal_clk;
    internal_clk = ~(p.clock_in | p.clock_inhibit);
    if (!p.shift_load_n) begin
      decode_mode = pls_pkg::PLS_ST_LOAD;
    end else if (internal_clk) begin
      decode_mode = pls_pkg::PLS_ST_ARMED;
    end else begin
      decode_mode = pls_pkg::PLS_ST_HELD;
    end
  endfunction

  assign pins_raw.shift_load_n = SHIFT_LOAD_N;
  assign pins_raw.clock_in = CLOCK_IN;
  assign pins_raw.clock_inhibit = CLOCK_INHIBIT;
  assign pins_raw.serial_in = SERIAL_IN;
  assign pins_raw.parallel_in = PARALLEL_IN;

  pls_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .pins_async(pins_raw),
    .pins_sync(pins)
  );

  assign state_next = decode_mode(pins);

  // Previous mode, used to find the internal clock's rising edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= pls_pkg::PLS_ST_HELD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edge only from held to armed; leaving load straight into armed is
  // no edge, whatever the internal clock was while in load
  always_comb begin
    case (state_reg)
      pls_pkg::PLS_ST_HELD: begin
        shift_pulse = (state_next == pls_pkg::PLS_ST_ARMED);
      end
      pls_pkg::PLS_ST_LOAD: begin
        shift_pulse = 1'b0;
      end
      pls_pkg::PLS_ST_ARMED: begin
        shift_pulse = 1'b0;
      end
      default: begin
        shift_pulse = 1'b0;
      end
    endcase
  end

  // Chain moves from first stage toward last
  assign shifted[0] = pins.serial_in;
  genvar i;
  generate
    for (i = 1; i < `PLS_WIDTH; i = i + 1) begin : g_chain
      assign shifted[i] = stage_reg[i-1];
    end
  endgenerate

  always_comb begin
    case (state_next)
      pls_pkg::PLS_ST_LOAD: begin
        stage_next = pins.parallel_in;
      end
      pls_pkg::PLS_ST_ARMED: begin
        // Parallel inputs are not looked at here
        stage_next = shift_pulse ? shifted : stage_reg;
      end
      pls_pkg::PLS_ST_HELD: begin
        stage_next = stage_reg;
      end
      default: begin
        stage_next = stage_reg;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stage_reg <= `PLS_STAGE_RESET;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Outputs registered from the same next value as the stages
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FIRST_STAGE <= 1'b0;
      LAST_STAGE_OUT <= 1'b0;
      LAST_STAGE_OUT_N <= 1'b1;
    end else begin
      FIRST_STAGE <= stage_next[0];
      LAST_STAGE_OUT <= stage_next[`PLS_WIDTH-1];
      LAST_STAGE_OUT_N <= ~stage_next[`PLS_WIDTH-1];
    end
  end

endmodule

`default_nettype wire

// >>> dv/pls_shift_register_asserts.sv
/* Pin-level checker for the shift register; assumes its top ports. */
`default_nettype none
`include "pls_regs.svh"
module pls_shift_register_asserts (
  input wire logic REF_CLK, // Clock
  input wire logic RST, // Reset
  input wire logic SHIFT_LOAD_N, // Load
  input wire logic CLOCK_IN, // Clock pin
  input wire logic CLOCK_INHIBIT, // Inhibit
  input wire logic SERIAL_IN, // Serial
  input wire logic [`PLS_WIDTH-1:0] PARALLEL_IN, // Data
  input wire logic FIRST_STAGE, // Stage 0
  input wire logic LAST_STAGE_OUT, // Last
  input wire logic LAST_STAGE_OUT_N // Inverse
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_held; SHIFT_LOAD_N && (CLOCK_IN || CLOCK_INHIBIT); endsequence
  sequence s_armed; SHIFT_LOAD_N && !CLOCK_IN && !CLOCK_INHIBIT; endsequence
  a_out_pair: assert property (LAST_STAGE_OUT_N != LAST_STAGE_OUT)
    else $error("not inverse");
  a_load_first: assert property (!SHIFT_LOAD_N |->
    ##3 FIRST_STAGE == $past(PARALLEL_IN[0], 3)) else $error("no load");
  a_load_last: assert property (!SHIFT_LOAD_N |->
    ##3 LAST_STAGE_OUT == $past(PARALLEL_IN[7], 3)) else $error("no load");
  a_hold_clk: assert property (SHIFT_LOAD_N && CLOCK_IN |->
    ##3 $stable({FIRST_STAGE, LAST_STAGE_OUT})) else $error("moved");
  a_hold_inh: assert property (SHIFT_LOAD_N && CLOCK_INHIBIT |->
    ##3 $stable({FIRST_STAGE, LAST_STAGE_OUT})) else $error("moved");
  a_armed_stay: assert property (s_armed ##1 s_armed |->
    ##3 $stable({FIRST_STAGE, LAST_STAGE_OUT})) else $error("moved");
  a_shift_in: assert property (s_held ##1 s_armed |->
    ##3 FIRST_STAGE == $past(SERIAL_IN, 3)) else $error("no shift");
  a_reset_out: assert property (disable iff (1'b0) RST |=>
    !FIRST_STAGE && !LAST_STAGE_OUT) else $error("reset value");
endmodule
bind pls_shift_register pls_shift_register_asserts i_chk (.REF_CLK(REF_CLK),
  .RST(RST), .SHIFT_LOAD_N(SHIFT_LOAD_N), .CLOCK_IN(CLOCK_IN),
  .CLOCK_INHIBIT(CLOCK_INHIBIT), .SERIAL_IN(SERIAL_IN),
  .PARALLEL_IN(PARALLEL_IN), .FIRST_STAGE(FIRST_STAGE),
  .LAST_STAGE_OUT(LAST_STAGE_OUT), .LAST_STAGE_OUT_N(LAST_STAGE_OUT_N));
`default_nettype wire

// >>> dv/pls_host_model.sv
/* Host driving the pins; assumes each level held four clk cycles. */
`default_nettype none
`include "pls_regs.svh"
module pls_host_model (
  input wire logic clk, // Reference clock
  output logic shift_load_n, // Load control
  output logic clock_in, // Gated clock
  output logic clock_inhibit, // Gated inhibit
  output logic serial_in, // Serial data
  output logic [`PLS_WIDTH-1:0] parallel_in // Parallel data
);
  initial {shift_load_n, clock_in, clock_inhibit, serial_in, parallel_in} =
    12'hC00;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set(input logic l, c, i, s,
      input logic [`PLS_WIDTH-1:0] p);
    if (i && !clock_inhibit && !clock_in) i = 1'b0;
    {shift_load_n, clock_in, clock_inhibit, serial_in, parallel_in} =
      {l, c, i, s, p};
    step(4);
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/* Self-checking bench; assumes design, checker and host model. */
`default_nettype none
`include "pls_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int L = `PLS_WIDTH - 1;
  logic clk, rst, load_n, clk_pin, inhibit, s_in, first, last, last_n;
  logic [L:0] par, shadow;
  int mismatches = 0;
  int compares = 0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  pls_host_model i_host (.clk(clk), .shift_load_n(load_n),
    .clock_in(clk_pin), .clock_inhibit(inhibit), .serial_in(s_in),
    .parallel_in(par));
  pls_shift_register i_dut (.REF_CLK(clk), .RST(rst),
    .SHIFT_LOAD_N(load_n), .CLOCK_IN(clk_pin), .CLOCK_INHIBIT(inhibit),
    .SERIAL_IN(s_in), .PARALLEL_IN(par), .FIRST_STAGE(first),
    .LAST_STAGE_OUT(last), .LAST_STAGE_OUT_N(last_n));
  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk;
    compares++;
    if (first !== shadow[0] || last !== shadow[L] || last_n !== ~shadow[L])
    begin
      mismatches++;
      $display("BAD %0t outputs differ", $time);
    end
  endtask
  task automatic t_load(input logic [L:0] d);
    i_host.set(1'b0, 1'b1, 1'b0, 1'b1, ~d);
    i_host.set(1'b0, 1'b0, 1'b0, 1'b0, d);
    shadow = d;
    chk();
    i_host.set(1'b1, 1'b1, 1'b0, 1'b1, ~d);
    chk();
  endtask
  task automatic t_shift;
    for (int k = 0; k < 9; k++) begin
      i_host.set(1'b1, 1'b0, 1'b0, k[0], ~shadow);
      shadow = {shadow[L-1:0], k[0]};
      chk();
      i_host.set(1'b1, 1'b1, 1'b0, ~k[0], shadow);
      chk();
    end
  endtask
  task automatic t_gate;
    i_host.set(1'b1, 1'b1, 1'b1, 1'b1, ~shadow);
    i_host.set(1'b1, 1'b0, 1'b1, 1'b0, shadow);
    chk();
    i_host.set(1'b1, 1'b0, 1'b0, 1'b1, ~shadow);
    shadow = {shadow[L-1:0], 1'b1};
    chk();
    i_host.step(40);
    chk();
  endtask
  task automatic t_reset;
    i_host.set(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    rst = 1'b1;
    i_host.step(2);
    rst = 1'b0;
    shadow = 8'h00;
    chk();
    i_host.step(4);
    chk();
  endtask
  initial begin
    rst = 1'b1;
    shadow = 8'h00;
    i_host.step(12);
    rst = 1'b0;
    chk();
    t_load(8'hA5);
    t_load(8'h5A);
    t_shift();
    t_gate();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
